// File: half_bridge_fault_supervisor.sv
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
// Notes on behaviour
// - reset clears counters, registers, drivers off
// - logic undervoltage: outputs off, registers cleared
// - drivers stay on until supply, command, fault
// - stage undervoltage: drivers off, supply fail set
// - stage undervoltage keeps port and programmed state
// - stage recovery restores outputs, clears supply fail
// - overvoltage sets supply fail, self clearing
// - lockout enabled: overvoltage forces outputs off
// - lockout disabled: overvoltage leaves outputs unchanged
// - persistent overcurrent latches bridge off, flags
// - overcurrent flag cleared only by reset request, enable toggle or logic undervoltage
// - long under-load while driving sets flag
// - under-load shutdown control latches bridge off
// - one shared under-load timer, remainder only
// - under-load flag and latch held until request
// - thermal warning flag follows temperature, drivers stay
// - thermal shutdown latches its bridge, sets flag
// - shutdown clears on request and cool sensor
// - latched-off fault zeroes enable and config bits
// - enable toggle or reset also clears latches
// - bad-length frame ignored entirely
`include "hb_fault_regs.svh"

module half_bridge_fault_supervisor (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // comparator and pin levels, asynchronous
  input wire hb_fault_pkg::analog_type analog_raw,
  // frame from serial shifter, same clock
  input wire logic frame_strobe,
  input wire logic frame_length_ok,
  input wire hb_fault_pkg::command_type frame_cmd,
  // register port
  input wire hb_fault_pkg::bus_req_type bus_req,
  output logic [31:0] rdata,
  // driver stages and status
  output logic [5:0] hs_on,
  output logic [5:0] ls_on,
  output hb_fault_pkg::status_type status
);
  import hb_fault_pkg::*;

  localparam logic [`OC_CNT_W-1:0] OC_LAST = `OC_CNT_W'(`OC_DELAY_CYC - 1);
  localparam logic [`ULD_CNT_W-1:0] ULD_LAST = `ULD_CNT_W'(`ULD_DELAY_CYC - 1);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  analog_type meta;
  analog_type sync;
  logic enable_prev;
  logic enable_toggle;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync <= '0;
      enable_prev <= 1'b0;
    end else begin
      meta <= analog_raw;
      sync <= meta;
      enable_prev <= sync.enable_pin;
    end
  end

  assign enable_toggle = sync.enable_pin ^ enable_prev;

  // ----------------------------------------
  // command intake
  // ----------------------------------------
  logic bus_cmd_write;
  logic cmd_take;
  command_type cmd_in;
  logic clear_req;

  // a valid frame wins if both arrive together; a bad one must not mask the bus write
  assign bus_cmd_write = bus_req.wr && (bus_req.addr == `CMD_OFFSET);
  assign cmd_take = (frame_strobe && frame_length_ok) || bus_cmd_write;
  assign cmd_in = (frame_strobe && frame_length_ok) ? frame_cmd
                  : command_type'(bus_req.wdata[15:0]);
  assign clear_req = (cmd_take && cmd_in.status_reset_request) || enable_toggle;

  function automatic logic [5:0] drive_mask(input command_type c, input logic [5:0] latched,
                                            input logic ok, input logic high);
    logic [5:0] sel;
    sel = high ? c.bridge_config_cmd : ~c.bridge_config_cmd;
    drive_mask = ok ? (c.bridge_enable_cmd & ~latched & sel) : 6'h00;
  endfunction : drive_mask

  // ----------------------------------------
  // overcurrent persistence, per bridge
  // ----------------------------------------
  logic [5:0] oc_trip;
  logic [`OC_CNT_W-1:0] oc_cnt [6];

  generate
    for (genvar i = 0; i < 6; i++) begin : g_oc
      logic [`OC_CNT_W-1:0] next_oc_cnt;
      always_comb begin
        if (!sync.sense.overcurrent[i] || sync.vcc_uv) begin
          next_oc_cnt = '0;
        end else if (oc_cnt[i] == OC_LAST) begin
          next_oc_cnt = oc_cnt[i];
        end else begin
          next_oc_cnt = oc_cnt[i] + `OC_CNT_W'(1);
        end
      end
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          oc_cnt[i] <= '0;
        end else begin
          oc_cnt[i] <= next_oc_cnt;
        end
      end
      assign oc_trip[i] = sync.sense.overcurrent[i] && (oc_cnt[i] == OC_LAST);
    end
  endgenerate

  // ----------------------------------------
  // shared under-load timer
  // ----------------------------------------
  logic [`ULD_CNT_W-1:0] uld_timer;
  logic [`ULD_CNT_W-1:0] next_uld_timer;
  logic [5:0] uld_active;
  logic uld_any;
  logic uld_trip;

  // only bridges actually driven can be judged for load current
  assign uld_active = sync.sense.under_load & (hs_on | ls_on);
  assign uld_any = |uld_active;
  assign uld_trip = uld_any && (uld_timer == ULD_LAST);

  // a late bridge joins the running count, so it waits the remainder only
  always_comb begin
    if (!uld_any || sync.vcc_uv) begin
      next_uld_timer = '0;
    end else if (uld_timer == ULD_LAST) begin
      next_uld_timer = uld_timer;
    end else begin
      next_uld_timer = uld_timer + `ULD_CNT_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      uld_timer <= '0;
    end else begin
      uld_timer <= next_uld_timer;
    end
  end

  // ----------------------------------------
  // command, latches, flags, drivers
  // ----------------------------------------
  command_type cmd;
  command_type next_cmd;
  logic [5:0] fault_latch;
  logic [5:0] next_fault_latch;
  logic [5:0] tsd_latch;
  logic [5:0] next_tsd_latch;
  logic [5:0] kill;
  logic drive_ok;
  status_type next_status;
  logic [5:0] next_hs;
  logic [5:0] next_ls;

  always_comb begin
    next_cmd = cmd;
    next_fault_latch = fault_latch;
    next_tsd_latch = tsd_latch;
    next_status = status;
    kill = 6'h00;
    // clear first so that a fault in the same cycle still sets
    if (clear_req) begin
      next_status.overcurrent_flag = 1'b0;
      next_status.under_load_flag = 1'b0;
      next_fault_latch = 6'h00;
      next_tsd_latch = tsd_latch & sync.sense.thermal_shutdown;
      if (sync.sense.thermal_shutdown == 6'h00) begin
        next_status.tsd_flag = 1'b0;
      end
    end
    // still latched bridges refuse new enables until cleared
    if (cmd_take) begin
      next_cmd = cmd_in;
      next_cmd.spare = 1'b0;
      next_cmd.bridge_enable_cmd = cmd_in.bridge_enable_cmd & ~(fault_latch | tsd_latch);
      next_cmd.bridge_config_cmd = cmd_in.bridge_config_cmd & ~(fault_latch | tsd_latch);
    end
    if (|oc_trip) begin
      next_status.overcurrent_flag = 1'b1;
      kill = kill | oc_trip;
    end
    if (uld_trip) begin
      next_status.under_load_flag = 1'b1;
      if (cmd.under_load_shutdown_ctrl) begin
        kill = kill | uld_active;
      end
    end
    if (|sync.sense.thermal_shutdown) begin
      next_status.tsd_flag = 1'b1;
      next_tsd_latch = next_tsd_latch | sync.sense.thermal_shutdown;
    end
    next_fault_latch = next_fault_latch | kill;
    kill = kill | sync.sense.thermal_shutdown;
    next_cmd.bridge_enable_cmd = next_cmd.bridge_enable_cmd & ~kill;
    next_cmd.bridge_config_cmd = next_cmd.bridge_config_cmd & ~kill;
    next_status.supply_fail_flag = sync.vs_uv || sync.vs_ov;
    next_status.thermal_warning_flag = |sync.sense.thermal_warning;
    if (sync.vcc_uv) begin
      next_cmd = command_type'(`CMD_RESET);
      next_fault_latch = 6'h00;
      next_tsd_latch = 6'h00;
      next_status = status_type'(`STATUS_RESET);
    end
    next_status.enabled = next_cmd.bridge_enable_cmd;
    next_status.config_report = next_cmd.bridge_config_cmd;
    // stage supply faults gate the drivers only; the command stays put (logic undervoltage resets it)
    drive_ok = !sync.vcc_uv && !sync.vs_uv
               && !(sync.vs_ov && next_cmd.overvoltage_lockout_enable);
    next_hs = drive_mask(next_cmd, next_fault_latch | next_tsd_latch, drive_ok, 1'b1);
    next_ls = drive_mask(next_cmd, next_fault_latch | next_tsd_latch, drive_ok, 1'b0);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmd <= command_type'(`CMD_RESET);
      fault_latch <= 6'h00;
      tsd_latch <= 6'h00;
      status <= status_type'(`STATUS_RESET);
      hs_on <= 6'h00;
      ls_on <= 6'h00;
    end else begin
      cmd <= next_cmd;
      fault_latch <= next_fault_latch;
      tsd_latch <= next_tsd_latch;
      status <= next_status;
      hs_on <= next_hs;
      ls_on <= next_ls;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = `RDATA_RESET;
    if (bus_req.rd) begin
      case (bus_req.addr)
        `CMD_OFFSET: begin
          next_rdata = {16'h0000, cmd};
        end
        `STATUS_OFFSET: begin
          next_rdata = {15'h0000, status};
        end
        `SENSE_OFFSET: begin
          next_rdata = {4'h0, sync};
        end
        default: begin
          next_rdata = `RDATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= `RDATA_RESET;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // run length of bridge 0 overcurrent kept apart from the design's counter
  localparam logic [7:0] OC_RUN_MIN = 8'(`OC_DELAY_CYC - 1);

  logic [7:0] oc_run;
  logic [7:0] next_oc_run;

  always_comb begin
    if (!sync.sense.overcurrent[0]) begin
      next_oc_run = 8'h00;
    end else if (oc_run == 8'hFF) begin
      next_oc_run = oc_run;
    end else begin
      next_oc_run = oc_run + 8'h01;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oc_run <= 8'h00;
    end else begin
      oc_run <= next_oc_run;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_logic_uv_clear: assert property (
    sync.vcc_uv |=> (hs_on == 6'h00) && (ls_on == 6'h00) && (cmd == '0) && (status == '0))
    else $error("logic undervoltage left drivers or registers set");

  a_stage_uv_off: assert property (
    sync.vs_uv && !sync.vcc_uv |=> (hs_on == 6'h00) && (ls_on == 6'h00)
    && status.supply_fail_flag)
    else $error("stage undervoltage did not stop drivers or flag");

  a_stage_uv_keep: assert property (
    sync.vs_uv && !sync.vcc_uv && !cmd_take && kill == 6'h00 && !clear_req
    |=> cmd == $past(cmd))
    else $error("stage undervoltage lost programmed state");

  a_stage_recover: assert property (
    $past(sync.vs_uv) && !sync.vs_uv && !sync.vs_ov && !sync.vcc_uv
    |=> !status.supply_fail_flag && (hs_on | ls_on) == (cmd.bridge_enable_cmd
        & ~(fault_latch | tsd_latch)))
    else $error("stage recovery did not restore outputs");

  a_ov_flag: assert property (
    sync.vs_ov && !sync.vcc_uv |=> status.supply_fail_flag)
    else $error("overvoltage did not set supply fail");

  a_ov_lockout: assert property (
    sync.vs_ov && !sync.vcc_uv && next_cmd.overvoltage_lockout_enable
    |=> hs_on == 6'h00 && ls_on == 6'h00 && cmd.overvoltage_lockout_enable)
    else $error("lockout did not force outputs off");

  a_ov_pass: assert property (
    sync.vs_ov && !sync.vs_uv && !sync.vcc_uv && !next_cmd.overvoltage_lockout_enable
    |=> (hs_on | ls_on) == (cmd.bridge_enable_cmd & ~(fault_latch | tsd_latch)))
    else $error("overvoltage without lockout changed outputs");

  a_oc_latch: assert property (
    oc_trip[0] && !sync.vcc_uv
    |=> fault_latch[0] && status.overcurrent_flag && !hs_on[0] && !ls_on[0])
    else $error("overcurrent did not latch bridge off");

  a_oc_delay: assert property (
    oc_trip[0] |-> oc_run >= OC_RUN_MIN)
    else $error("overcurrent tripped before its delay");

  a_oc_hold: assert property (
    status.overcurrent_flag && !clear_req && !sync.vcc_uv |=> status.overcurrent_flag)
    else $error("overcurrent flag dropped without request");

  a_uld_flag: assert property (
    uld_trip && !sync.vcc_uv |=> status.under_load_flag)
    else $error("under-load expiry did not set flag");

  a_uld_shared: assert property (
    uld_any && !sync.vcc_uv && uld_timer != ULD_LAST |=> uld_timer == $past(uld_timer) + 1)
    else $error("shared under-load timer restarted");

  a_tw_follow: assert property (
    !sync.vcc_uv |=> status.thermal_warning_flag == $past(|sync.sense.thermal_warning))
    else $error("thermal warning flag does not follow sensors");

  a_tsd_hold: assert property (
    status.tsd_flag && (|sync.sense.thermal_shutdown) && !sync.vcc_uv |=> status.tsd_flag)
    else $error("thermal shutdown cleared while hot");

  a_fault_zero: assert property (
    kill[0] && !sync.vcc_uv |=> !cmd.bridge_enable_cmd[0] && !cmd.bridge_config_cmd[0])
    else $error("latched fault left command bits set");

  a_bad_frame: assert property (
    frame_strobe && !frame_length_ok && !bus_cmd_write && !enable_toggle
    && !sync.vcc_uv && kill == 6'h00 |=> cmd == $past(cmd))
    else $error("bad-length frame changed command");

  c_oc_shutdown: cover property (oc_trip[0] ##1 status.overcurrent_flag ##[1:20] !status.overcurrent_flag);
  c_uld_latch: cover property (uld_trip && cmd.under_load_shutdown_ctrl);
  c_tsd_clear: cover property (status.tsd_flag ##[1:50] !status.tsd_flag);
  c_ov_lockout: cover property (sync.vs_ov && cmd.overvoltage_lockout_enable && cmd.bridge_enable_cmd != 6'h00);

endmodule : half_bridge_fault_supervisor

// File: hb_fault_pkg.sv
package hb_fault_pkg;

  // command word: srr 15, spare 14, under_load_shutdown_ctrl 13, enables 12..7, configs 6..1, overvoltage_lockout_enable 0
  typedef struct packed {
    logic status_reset_request;
    logic spare;
    logic under_load_shutdown_ctrl;
    logic [5:0] bridge_enable_cmd;
    logic [5:0] bridge_config_cmd;
    logic overvoltage_lockout_enable;
  } command_type;

  // status word: tsd ahead of bit 15, then 15..0 as shifted out
  typedef struct packed {
    logic tsd_flag;
    logic overcurrent_flag;
    logic supply_fail_flag;
    logic under_load_flag;
    logic [5:0] enabled;
    logic [5:0] config_report;
    logic thermal_warning_flag;
  } status_type;

  typedef struct packed {
    logic [5:0] overcurrent;
    logic [5:0] under_load;
    logic [5:0] thermal_warning;
    logic [5:0] thermal_shutdown;
  } sense_type;

  typedef struct packed {
    logic vcc_uv;
    logic vs_uv;
    logic vs_ov;
    logic enable_pin;
    sense_type sense;
  } analog_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

endpackage : hb_fault_pkg

// File: hb_fault_regs.svh
`ifndef HB_FAULT_REGS_SVH
`define HB_FAULT_REGS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define OC_DELAY_NS 10000
`define OC_DELAY_CYC ((`OC_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ULD_DELAY_NS 200000
`define ULD_DELAY_CYC ((`ULD_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OC_CNT_W 7
`define ULD_CNT_W 12

// ----------------------------------------
// register map
// ----------------------------------------
`define CMD_OFFSET 4'h0
`define STATUS_OFFSET 4'h4
`define SENSE_OFFSET 4'h8

// ----------------------------------------
// reset values
// ----------------------------------------
`define CMD_RESET 16'h0000
`define STATUS_RESET 17'h00000
`define RDATA_RESET 32'h00000000

`endif

// File: spi_master_model.sv
`timescale 1ns/100ps
// ---
// serial master stand-in
// ---
module spi_master_model (
  // clock
  input wire logic clock,
  // frame handoff
  output hb_fault_pkg::command_type frame_cmd,
  output logic frame_strobe,
  output logic frame_length_ok,
  // register port
  output hb_fault_pkg::bus_req_type bus_req,
  input wire logic [31:0] rdata
);
  import hb_fault_pkg::*;

  initial begin
    frame_cmd = '0;
    frame_strobe = 1'h0;
    frame_length_ok = 1'h0;
    bus_req = '0;
  end

  // released fields go to the inverse so a stale value is never trusted
  task automatic send(input command_type c, input logic ok, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    frame_cmd <= c;
    frame_length_ok <= ok;
    frame_strobe <= 1'h1;
    @(posedge clock);
    frame_cmd <= ~c;
    frame_length_ok <= ~ok;
    frame_strobe <= 1'h0;
  endtask : send

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    bus_req <= '{a, v, 1'h1, 1'h0};
    @(posedge clock);
    bus_req <= '{~a, ~v, 1'h0, 1'h0};
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock);
    bus_req <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge clock);
    bus_req <= '{~a, 32'hFFFFFFFF, 1'h0, 1'h0};
    #1;
    v = rdata;
  endtask : rd
endmodule : spi_master_model

// File: test_half_bridge_fault_supervisor.sv
`timescale 1ns/100ps
module test_half_bridge_fault_supervisor;
  import hb_fault_pkg::*;
  logic clock = 1'h0;
  logic rst = 1'h1;
  analog_type an = '0;
  logic fs;
  logic fok;
  command_type fc;
  bus_req_type br;
  logic [31:0] rdata;
  logic [5:0] hs_on;
  logic [5:0] ls_on;
  status_type status;
  logic [31:0] d;
  int fails = 0;
  int check_count = 0;

  always #50 clock = ~clock;

  half_bridge_fault_supervisor half_bridge_fault_supervisor_i (
    .clock(clock), .rst(rst), .analog_raw(an), .frame_strobe(fs),
    .frame_length_ok(fok), .frame_cmd(fc), .bus_req(br), .rdata(rdata),
    .hs_on(hs_on), .ls_on(ls_on), .status(status));

  spi_master_model spi_master_model_i (
    .clock(clock), .frame_cmd(fc), .frame_strobe(fs),
    .frame_length_ok(fok), .bus_req(br), .rdata(rdata));

  // ---
  // helpers
  // ---
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", n, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  function automatic command_type mk(logic s, logic u, logic [5:0] e, logic [5:0] f, logic o);
    mk = '{s, 1'h0, u, e, f, o};
  endfunction : mk

  task automatic go(input command_type c);
    spi_master_model_i.send(c, 1'h1, 0);
    cyc(1);
  endtask : go

  task automatic report_and_stop;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // ---
  // scenarios
  // ---
  task automatic t_reset;
    repeat (5) @(posedge clock);
    chk("hs_rst", hs_on, 6'h00);
    chk("st_rst", status, 17'h0);
    rst <= 1'h0;
    cyc(1);
    chk("ls_rst", ls_on, 6'h00);
  endtask : t_reset

  task automatic t_frame;
    go(mk(1'h0, 1'h0, 6'h03, 6'h01, 1'h1));
    chk("hs", hs_on, 6'h01);
    chk("ls", ls_on, 6'h02);
    chk("en", status.enabled, 6'h03);
    chk("cr", status.config_report, 6'h01);
    spi_master_model_i.send(mk(1'h0, 1'h0, 6'h00, 6'h00, 1'h1), 1'h0, 3);
    cyc(2);
    chk("hs_bad", hs_on, 6'h01);
  endtask : t_frame

  task automatic t_supply;
    @(posedge clock);
    an.vs_uv <= 1'h1;
    cyc(5);
    chk("hs_uv", hs_on | ls_on, 6'h00);
    chk("psf_uv", status.supply_fail_flag, 1'h1);
    go(mk(1'h0, 1'h0, 6'h07, 6'h05, 1'h1));
    chk("en_uv", status.enabled, 6'h07);
    @(posedge clock);
    an.vs_uv <= 1'h0;
    cyc(5);
    chk("hs_back", hs_on, 6'h05);
    chk("psf_back", status.supply_fail_flag, 1'h0);
    @(posedge clock);
    an.vs_ov <= 1'h1;
    cyc(5);
    chk("hs_ov", hs_on | ls_on, 6'h00);
    chk("psf_ov", status.supply_fail_flag, 1'h1);
    go(mk(1'h0, 1'h0, 6'h07, 6'h05, 1'h0));
    chk("hs_ov0", hs_on, 6'h05);
    chk("psf_ov0", status.supply_fail_flag, 1'h1);
    go(mk(1'h0, 1'h0, 6'h07, 6'h05, 1'h1));
    chk("ls_ov1", ls_on, 6'h00);
    @(posedge clock);
    an.vs_ov <= 1'h0;
    cyc(5);
    chk("ls_ovc", ls_on, 6'h02);
    chk("psf_ovc", status.supply_fail_flag, 1'h0);
  endtask : t_supply

  task automatic t_overcurrent;
    @(posedge clock);
    an.sense.overcurrent[0] <= 1'h1;
    cyc(95);
    chk("hs_ocw", hs_on, 6'h05);
    cyc(10);
    chk("hs_oc", hs_on, 6'h04);
    chk("ocs", status.overcurrent_flag, 1'h1);
    chk("en_oc", status.enabled, 6'h06);
    chk("cr_oc", status.config_report, 6'h04);
    @(posedge clock);
    an.sense.overcurrent[0] <= 1'h0;
    cyc(5);
    spi_master_model_i.send(mk(1'h1, 1'h0, 6'h07, 6'h05, 1'h1), 1'h0, 0);
    cyc(2);
    chk("ocs_bad", status.overcurrent_flag, 1'h1);
    go(mk(1'h0, 1'h0, 6'h07, 6'h05, 1'h1));
    chk("ocs_keep", status.overcurrent_flag, 1'h1);
    chk("hs_keep", hs_on, 6'h04);
    go(mk(1'h1, 1'h0, 6'h06, 6'h04, 1'h1));
    chk("ocs_clr", status.overcurrent_flag, 1'h0);
    go(mk(1'h0, 1'h0, 6'h07, 6'h05, 1'h1));
    chk("hs_re", hs_on, 6'h05);
  endtask : t_overcurrent

  task automatic t_underload;
    @(posedge clock);
    an.sense.under_load[1] <= 1'h1;
    cyc(1990);
    chk("uld_early", status.under_load_flag, 1'h0);
    cyc(20);
    chk("uld", status.under_load_flag, 1'h1);
    chk("ls_uld0", ls_on, 6'h02);
    @(posedge clock);
    an.sense.under_load[1] <= 1'h0;
    cyc(5);
    chk("uld_hold", status.under_load_flag, 1'h1);
    go(mk(1'h1, 1'h1, 6'h07, 6'h05, 1'h1));
    chk("uld_clr", status.under_load_flag, 1'h0);
    @(posedge clock);
    an.sense.under_load[0] <= 1'h1;
    cyc(1000);
    @(posedge clock);
    an.sense.under_load[2] <= 1'h1;
    cyc(985);
    chk("uld_rem", status.under_load_flag, 1'h0);
    cyc(20);
    chk("drv_uld", hs_on | ls_on, 6'h02);
    chk("en_uld", status.enabled, 6'h02);
    @(posedge clock);
    an.sense.under_load[0] <= 1'h0;
    an.sense.under_load[2] <= 1'h0;
    go(mk(1'h0, 1'h1, 6'h07, 6'h05, 1'h1));
    chk("hs_uldk", hs_on, 6'h00);
    go(mk(1'h1, 1'h0, 6'h07, 6'h05, 1'h1));
    go(mk(1'h0, 1'h0, 6'h07, 6'h05, 1'h1));
    chk("hs_uldr", hs_on, 6'h05);
  endtask : t_underload

  task automatic t_thermal;
    @(posedge clock);
    an.sense.thermal_warning[2] <= 1'h1;
    cyc(5);
    chk("tw", status.thermal_warning_flag, 1'h1);
    chk("hs_tw", hs_on, 6'h05);
    @(posedge clock);
    an.sense.thermal_warning[2] <= 1'h0;
    an.sense.thermal_shutdown[2] <= 1'h1;
    cyc(5);
    chk("tw_off", status.thermal_warning_flag, 1'h0);
    chk("hs_tsd", hs_on, 6'h01);
    chk("ls_tsd", ls_on, 6'h02);
    chk("tsd", status.tsd_flag, 1'h1);
    go(mk(1'h1, 1'h0, 6'h03, 6'h01, 1'h1));
    chk("tsd_hot", status.tsd_flag, 1'h1);
    @(posedge clock);
    an.sense.thermal_shutdown[2] <= 1'h0;
    cyc(5);
    chk("tsd_cool", status.tsd_flag, 1'h1);
    go(mk(1'h1, 1'h0, 6'h03, 6'h01, 1'h1));
    chk("tsd_clr", status.tsd_flag, 1'h0);
  endtask : t_thermal

  task automatic t_toggle;
    @(posedge clock);
    an.sense.overcurrent[1] <= 1'h1;
    cyc(105);
    chk("ls_oc", ls_on, 6'h00);
    @(posedge clock);
    an.sense.overcurrent[1] <= 1'h0;
    cyc(5);
    @(posedge clock);
    an.enable_pin <= 1'h1;
    cyc(6);
    chk("ocs_tog", status.overcurrent_flag, 1'h0);
    go(mk(1'h0, 1'h0, 6'h03, 6'h01, 1'h1));
    chk("ls_tog", ls_on, 6'h02);
  endtask : t_toggle

  task automatic t_bus;
    spi_master_model_i.wr(4'h0, 32'h00000083);
    spi_master_model_i.rd(4'h4, d);
    chk("rd_st", d, 32'h00000082);
    spi_master_model_i.rd(4'hC, d);
    chk("rd_bad", d, 32'h0);
    spi_master_model_i.rd(4'h0, d);
    chk("rd_cmd", d, 32'h00000083);
    spi_master_model_i.wr(4'h4, 32'h00000000);
    spi_master_model_i.rd(4'h0, d);
    chk("rd_keep", d, 32'h00000083);
    spi_master_model_i.rd(4'h8, d);
    chk("rd_sense", d, 32'h01000000);
    cyc(1);
    chk("rd_idle", rdata, 32'h0);
    chk("hs_bus", hs_on, 6'h01);
  endtask : t_bus

  task automatic t_vcc;
    @(posedge clock);
    an.vcc_uv <= 1'h1;
    cyc(5);
    chk("drv_vcc", hs_on | ls_on, 6'h00);
    chk("st_vcc", status, 17'h0);
    @(posedge clock);
    an.vcc_uv <= 1'h0;
    cyc(5);
    chk("hs_vccr", hs_on, 6'h00);
    chk("st_vccr", status, 17'h0);
  endtask : t_vcc

  // ---
  // sequence
  // ---
  initial begin
    t_reset();
    t_frame();
    t_supply();
    t_overcurrent();
    t_underload();
    t_thermal();
    t_toggle();
    t_bus();
    t_vcc();
    report_and_stop();
  end

  // whole run is about 4400 cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    report_and_stop();
  end
endmodule : test_half_bridge_fault_supervisor
